// ==== rtl/tpfs_pkg.sv ====
// shared constants and types for the table pointer flash sequencer
// assumes a single 20 MHz core clock and an active-low asynchronous reset
package tpfs_pkg;

  // pointer geometry
  localparam int PTR_W = 22;          // full table pointer width
  localparam int LOW_W = 21;          // program space part of the pointer
  localparam int HOLD_AW = 5;         // low pointer bits that pick a holding register
  localparam int HOLD_BYTES = 32;     // holding registers in one write block
  localparam int ERASE_LSB = 6;       // lowest pointer bit of an erase block address
  localparam int ERASE_BLK_W = 16;    // pointer bits 21:6
  localparam int WRITE_BLK_W = 17;    // pointer bits 21:5

  // register port offsets
  localparam int REG_AW = 3;
  localparam logic [2:0] OFF_PTR_LOW = 3'h0;
  localparam logic [2:0] OFF_PTR_HIGH = 3'h1;
  localparam logic [2:0] OFF_PTR_UPPER = 3'h2;
  localparam logic [2:0] OFF_LATCH = 3'h3;
  localparam logic [2:0] OFF_CTRL = 3'h4;
  localparam logic [2:0] OFF_UNLOCK = 3'h5;
  localparam logic [2:0] OFF_STATUS = 3'h6;

  // control register field positions
  localparam int CTRL_PGM_BIT = 7;
  localparam int CTRL_CFG_BIT = 6;
  localparam int CTRL_ERASE_BIT = 4;
  localparam int CTRL_ABORT_BIT = 3;
  localparam int CTRL_PERMIT_BIT = 2;
  localparam int CTRL_START_BIT = 1;
  localparam int STAT_DONE_BIT = 0;

  // reset values and keys
  localparam logic [21:0] PTR_RESET = 22'h000000;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic [7:0] HOLD_RESET = 8'hFF;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;

  // programming timer
  localparam int CLK_PERIOD_NS = 50;
  localparam int PROG_TIME_NS = 2000000;
  localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 16;

  // pointer update modes of a table instruction
  typedef enum logic [1:0] {
    TPFS_KEEP,
    TPFS_POST_INC,
    TPFS_POST_DEC,
    TPFS_PRE_INC
  } tpfs_mode_t;

  // one table instruction from the core
  typedef struct packed {
    logic isWrite;
    tpfs_mode_t mode;
  } tpfs_tbl_req_t;

  // self-timed command handed to the flash array
  typedef struct packed {
    logic erase;
    logic cfgSpace;
    logic [ERASE_BLK_W-1:0] eraseBlk;
    logic [WRITE_BLK_W-1:0] writeBlk;
  } tpfs_flash_cmd_t;

endpackage

// ==== rtl/tpfs_prog_timer.sv ====
// programming timer: counts out one self-timed write or erase
// assumes start is a one-cycle pulse and only arrives while idle
`timescale 1ns/1ps
`default_nettype none
module tpfs_prog_timer
  import tpfs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [TMR_W-1:0] cycles,
  input wire logic start,
  input wire logic abort,
  output logic done
);

  logic [TMR_W-1:0] cnt_q; // cycles still to run
  logic run_q;             // an operation is being timed
  logic lastTick;          // final cycle of the interval

  assign lastTick = run_q && (cnt_q == TMR_W'(1));

  // load on start, count down, stop early on abort
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= cycles;
      run_q <= 1'b1;
    end else if (abort || lastTick) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (run_q) begin
      cnt_q <= cnt_q - TMR_W'(1);
    end
  end

  // an aborted operation never reports done
  assign done = lastTick && !abort;

endmodule
`default_nettype wire

// ==== rtl/tpfs_top.sv ====
// table pointer, table latch, holding registers and erase/write sequencing
// assumes the core issues table instructions on the same clock and that the
// flash array returns a word in the cycle its read enable is high
// Behaviour
// R01 - pointer is upper:high:low bytes, 22 bits
// R02 - low 21 bits program space, top bit config
// R03 - auto update never touches the top bit
// R04 - four modes: keep, post-inc, post-dec, pre-inc
// R05 - table read uses all 22 bits into latch
// R06 - table write fills holding register by low bits
// R07 - block write uses upper bits, drops offset bits
// R08 - erase targets block from bits 21:6
// R09 - pointer lsb selects high or low byte
// R10 - erase unit is 64 bytes only
// R11 - firmware sets memory, permit and erase bits
// R12 - start needs 55h then AAh unlock first
// R13 - core stalls until programming timer expires
// R14 - erase stall lasts about 2 ms
// R15 - firmware clears config select for program erase
// R16 - firmware loads pointer before unlocking
// R17 - erase bit picks erase, cleared on completion
// R18 - start set by software, cleared by hardware
// R19 - completion sets sticky done flag
// R20 - abort flag on premature end or misuse
// R21 - start without unlock or permit is ignored
// R22 - increment and decrement wrap in 21 bits
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module tpfs_top
  import tpfs_pkg::*;
#(
  parameter int unsigned PROG_CYCLES_P = PROG_CYCLES
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic tblReq,
  input wire tpfs_tbl_req_t tblCmd,
  output logic tblReady,
  output logic flashRdEn,
  output logic [LOW_W-1:0] flashRdAddr,
  input wire logic [15:0] flashRdData,
  output logic flashGo,
  output tpfs_flash_cmd_t flashCmd,
  output logic [HOLD_BYTES-1:0][7:0] holdData,
  input wire logic opAbort,
  output logic cpuStall
);

  typedef enum logic [1:0] {TPFS_UNL_IDLE, TPFS_UNL_HALF, TPFS_UNL_ARMED} tpfs_unl_t;

  logic [PTR_W-1:0] ptr_q;            // table pointer
  logic [PTR_W-1:0] ptr_d;
  logic [7:0] latch_q;                // table byte latch
  logic pgmSel_q;                     // program memory select
  logic cfgSel_q;                     // configuration space select
  logic eraseSel_q;                   // erase instead of write
  logic permit_q;                     // programming permitted
  logic start_q;                      // self-timed operation running
  logic abort_q;                      // premature end or misuse seen
  logic done_q;                       // sticky completion flag
  tpfs_unl_t unl_q;                   // unlock sequence progress
  tpfs_unl_t unl_d;
  logic opErase_q;                    // running operation is an erase
  logic byteSel_q;                    // byte of the word under read
  logic flashRdEn_q;
  logic [LOW_W-1:0] flashRdAddr_q;
  logic flashGo_q;
  tpfs_flash_cmd_t flashCmd_q;
  logic [7:0] regRdata_q;
  logic tmrDone;                      // timer expired this cycle

  // register port decode
  wire wrPtrL = regWr && (regAddr == OFF_PTR_LOW);
  wire wrPtrH = regWr && (regAddr == OFF_PTR_HIGH);
  wire wrPtrU = regWr && (regAddr == OFF_PTR_UPPER);
  wire wrLatch = regWr && (regAddr == OFF_LATCH);
  wire wrCtrl = regWr && (regAddr == OFF_CTRL) && !start_q;
  wire wrUnlock = regWr && (regAddr == OFF_UNLOCK);
  wire wrStatus = regWr && (regAddr == OFF_STATUS);
  wire ptrWr = wrPtrL || wrPtrH || wrPtrU;

  // table instruction decode; no table op while a read or a long write is open
  assign tblReady = !start_q && !flashRdEn_q; // R13
  wire tblTake = tblReq && tblReady;
  wire tblRead = tblTake && !tblCmd.isWrite;
  wire tblStore = tblTake && tblCmd.isWrite;

  // 21-bit wrap, the top bit is carried over untouched
  wire [LOW_W-1:0] ptrInc = ptr_q[LOW_W-1:0] + LOW_W'(1); // R22
  wire [LOW_W-1:0] ptrDec = ptr_q[LOW_W-1:0] - LOW_W'(1); // R22
  wire [PTR_W-1:0] ptrUp = {ptr_q[PTR_W-1], ptrInc}; // R03
  wire [PTR_W-1:0] ptrDown = {ptr_q[PTR_W-1], ptrDec}; // R03

  // address used by the access: pre-increment sees the bumped pointer
  wire [PTR_W-1:0] accAddr = (tblCmd.mode == TPFS_PRE_INC) ? ptrUp : ptr_q; // R04

  // pointer value after the table instruction
  logic [PTR_W-1:0] ptrAfter;
  always_comb begin
    unique case (tblCmd.mode) // R04
      TPFS_KEEP: ptrAfter = ptr_q;
      TPFS_POST_INC: ptrAfter = ptrUp;
      TPFS_POST_DEC: ptrAfter = ptrDown;
      TPFS_PRE_INC: ptrAfter = ptrUp;
    endcase
  end

  // software byte writes win over the table update in the same cycle
  always_comb begin
    ptr_d = ptr_q;
    if (ptrWr) begin
      if (wrPtrL) ptr_d[7:0] = regWdata; // R01
      if (wrPtrH) ptr_d[15:8] = regWdata; // R01
      if (wrPtrU) ptr_d[21:16] = regWdata[5:0]; // R01
    end else if (tblTake) begin
      ptr_d = ptrAfter;
    end
  end

  // pointer storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ptr_q <= PTR_RESET;
    else ptr_q <= ptr_d;
  end

  // table read: word address and byte choice go out one cycle after the take
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flashRdEn_q <= 1'b0;
      flashRdAddr_q <= '0;
      byteSel_q <= 1'b0;
    end else begin
      flashRdEn_q <= tblRead;
      if (tblRead) begin
        flashRdAddr_q <= accAddr[PTR_W-1:1]; // R05
        byteSel_q <= accAddr[0]; // R09
      end
    end
  end

  // odd byte is the high half of the word
  wire [7:0] rdByte = byteSel_q ? flashRdData[15:8] : flashRdData[7:0]; // R09

  // latch: the returning flash byte has priority over a software write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) latch_q <= LATCH_RESET;
    else if (flashRdEn_q) latch_q <= rdByte; // R05
    else if (wrLatch) latch_q <= regWdata;
  end

  // unlock tracking: any other register write breaks the pair
  always_comb begin
    unl_d = unl_q;
    if (wrUnlock && regWdata == UNLOCK_KEY1) unl_d = TPFS_UNL_HALF; // R12
    else if (wrUnlock && regWdata == UNLOCK_KEY2 && unl_q == TPFS_UNL_HALF) begin
      unl_d = TPFS_UNL_ARMED; // R12
    end else if (regWr) unl_d = TPFS_UNL_IDLE; // R21
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) unl_q <= TPFS_UNL_IDLE;
    else unl_q <= unl_d;
  end

  // start attempts; the permit bit is taken from the same write
  wire startWr = wrCtrl && regWdata[CTRL_START_BIT];
  wire goodStart = startWr && (unl_q == TPFS_UNL_ARMED) && regWdata[CTRL_PERMIT_BIT]; // R21
  wire badStart = startWr && !goodStart; // R21
  wire abortNow = opAbort && start_q; // R20

  // control fields: frozen while an operation runs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pgmSel_q <= 1'b0;
      cfgSel_q <= 1'b0;
      permit_q <= 1'b0;
    end else if (wrCtrl) begin
      pgmSel_q <= regWdata[CTRL_PGM_BIT];
      cfgSel_q <= regWdata[CTRL_CFG_BIT];
      permit_q <= regWdata[CTRL_PERMIT_BIT];
    end
  end

  // erase select: completion of an erase clears it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) eraseSel_q <= 1'b0;
    else if (tmrDone && opErase_q) eraseSel_q <= 1'b0; // R17
    else if (wrCtrl) eraseSel_q <= regWdata[CTRL_ERASE_BIT];
  end

  // start bit: software can only set it, hardware ends it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) start_q <= 1'b0;
    else if (goodStart) start_q <= 1'b1; // R18
    else if (tmrDone || abortNow) start_q <= 1'b0; // R18
  end

  // abort flag: hardware sets win over a software write of zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) abort_q <= 1'b0;
    else if (badStart || abortNow) abort_q <= 1'b1; // R20
    else if (wrCtrl) abort_q <= regWdata[CTRL_ABORT_BIT];
  end

  // done flag: write one to clear, completion in the same cycle wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) done_q <= 1'b0;
    else if (tmrDone) done_q <= 1'b1; // R19
    else if (wrStatus && regWdata[STAT_DONE_BIT]) done_q <= 1'b0;
  end

  // command capture at launch; erase always covers a whole 64-byte block
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flashGo_q <= 1'b0;
      flashCmd_q <= '0;
      opErase_q <= 1'b0;
    end else begin
      flashGo_q <= goodStart;
      if (goodStart) begin
        opErase_q <= eraseSel_q; // R17
        flashCmd_q.erase <= eraseSel_q; // R17
        flashCmd_q.cfgSpace <= cfgSel_q; // R02
        flashCmd_q.eraseBlk <= ptr_q[PTR_W-1:ERASE_LSB]; // R08 R10
        flashCmd_q.writeBlk <= ptr_q[PTR_W-1:HOLD_AW]; // R07
      end
    end
  end

  // the programming interval; a long count, so it is a top parameter
  tpfs_prog_timer u_timer (
    .clk(clk),
    .rstn(rstn),
    .cycles(TMR_W'(PROG_CYCLES_P)),
    .start(goodStart),
    .abort(abortNow),
    .done(tmrDone)
  );

  // holding registers return to all ones after a block write
  wire holdClr = tmrDone && !opErase_q;

  genvar gi;
  generate
    for (gi = 0; gi < HOLD_BYTES; gi++) begin : g_hold
      wire hit = tblStore && (accAddr[HOLD_AW-1:0] == HOLD_AW'(gi)); // R06
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) holdData[gi] <= HOLD_RESET;
        else if (holdClr) holdData[gi] <= HOLD_RESET; // R07
        else if (hit) holdData[gi] <= latch_q; // R06
      end
    end
  endgenerate

  // register read mux; unused bits read zero
  wire [7:0] ctrlView = {pgmSel_q, cfgSel_q, 1'b0, eraseSel_q, abort_q, permit_q,
                         start_q, 1'b0};
  logic [7:0] rdMux;
  always_comb begin
    unique case (regAddr)
      OFF_PTR_LOW: rdMux = ptr_q[7:0];
      OFF_PTR_HIGH: rdMux = ptr_q[15:8];
      OFF_PTR_UPPER: rdMux = {2'h0, ptr_q[21:16]};
      OFF_LATCH: rdMux = latch_q;
      OFF_CTRL: rdMux = ctrlView;
      OFF_STATUS: rdMux = {7'h00, done_q};
      default: rdMux = 8'h00;
    endcase
  end

  // read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) regRdata_q <= 8'h00;
    else regRdata_q <= regRd ? rdMux : 8'h00;
  end

  assign regRdata = regRdata_q;
  assign flashRdEn = flashRdEn_q;
  assign flashRdAddr = flashRdAddr_q;
  assign flashGo = flashGo_q;
  assign flashCmd = flashCmd_q;
  assign cpuStall = start_q; // R13 R14

  // stall length watchdog for the assertion below
  logic [TMR_W:0] stallCnt_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) stallCnt_q <= '0;
    else if (!start_q) stallCnt_q <= '0;
    else stallCnt_q <= stallCnt_q + (TMR_W+1)'(1);
  end

  property p_top_bit_kept;
    @(posedge clk) disable iff (!rstn)
      tblTake && !ptrWr |=> ptr_q[PTR_W-1] == $past(ptr_q[PTR_W-1]);
  endproperty
  a_top_bit_kept: assert property (p_top_bit_kept) // R03
    else $error("table op changed pointer top bit");

  property p_post_dec_wraps;
    @(posedge clk) disable iff (!rstn)
      tblTake && !ptrWr && tblCmd.mode == TPFS_POST_DEC
      |=> ptr_q[LOW_W-1:0] == LOW_W'($past(ptr_q[LOW_W-1:0]) - LOW_W'(1));
  endproperty
  a_post_dec_wraps: assert property (p_post_dec_wraps) // R22
    else $error("post decrement result wrong");

  property p_read_byte;
    @(posedge clk) disable iff (!rstn)
      tblRead ##1 flashRdEn_q
      |=> latch_q == ($past(byteSel_q) ? $past(flashRdData[15:8]) : $past(flashRdData[7:0]));
  endproperty
  a_read_byte: assert property (p_read_byte) // R09
    else $error("latch did not take addressed byte");

  property p_store_hold;
    @(posedge clk) disable iff (!rstn)
      tblStore && !holdClr |=> holdData[$past(accAddr[HOLD_AW-1:0])] == $past(latch_q);
  endproperty
  a_store_hold: assert property (p_store_hold) // R06
    else $error("holding register not written from latch");

  property p_start_needs_unlock;
    @(posedge clk) disable iff (!rstn)
      $rose(start_q) |-> $past(unl_q) == TPFS_UNL_ARMED && $past(regWdata[CTRL_PERMIT_BIT]);
  endproperty
  a_start_needs_unlock: assert property (p_start_needs_unlock) // R12
    else $error("start accepted without unlock pair");

  property p_stall_bounded;
    @(posedge clk) disable iff (!rstn)
      stallCnt_q <= (TMR_W+1)'(PROG_CYCLES_P);
  endproperty
  a_stall_bounded: assert property (p_stall_bounded) // R14
    else $error("stall outlasted programming time");

  property p_done_ends_op;
    @(posedge clk) disable iff (!rstn)
      tmrDone |=> !start_q && done_q && !(opErase_q && eraseSel_q);
  endproperty
  a_done_ends_op: assert property (p_done_ends_op) // R17
    else $error("completion did not clear start and set done");

  property p_erase_block;
    @(posedge clk) disable iff (!rstn)
      goodStart |=> flashGo && flashCmd.eraseBlk == $past(ptr_q[PTR_W-1:ERASE_LSB]);
  endproperty
  a_erase_block: assert property (p_erase_block) // R08
    else $error("erase block address wrong");

  property p_bad_start_flag;
    @(posedge clk) disable iff (!rstn)
      badStart |=> abort_q && $stable(start_q);
  endproperty
  a_bad_start_flag: assert property (p_bad_start_flag) // R20
    else $error("improper start not flagged");

endmodule
`default_nettype wire

// ==== dv/tpfs_flash_model.sv ====
// behavioural model of the word-wide flash array behind the sequencer
// assumes the sequencer samples the word in the cycle its read enable is high
`timescale 1ns/1ps
`default_nettype none
module tpfs_flash_model
  import tpfs_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic flashRdEn,
  input wire logic [LOW_W-1:0] flashRdAddr,
  output logic [15:0] flashRdData
);
  logic [15:0] junk_q; // filler that flips every cycle outside reads
  logic [15:0] wordVal; // stored word, a pure function of the word address

  // high byte and low byte differ so a swapped byte lane shows up
  assign wordVal = {flashRdAddr[7:0] ^ 8'h96, flashRdAddr[15:8] ^ flashRdAddr[7:0]};
  // data only while enabled, otherwise a moving pattern so stale data never passes
  assign flashRdData = flashRdEn ? wordVal : junk_q;

  // filler pattern generator
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      junk_q <= 16'hA55A;
    end else begin
      junk_q <= ~junk_q;
    end
  end
endmodule
`default_nettype wire

// ==== dv/tpfs_tb_top.sv ====
// self-checking bench for the table pointer flash sequencer
// assumes the flash array model answers in the same cycle as the read enable
`timescale 1ns/1ps
`default_nettype none
module tpfs_tb_top
  import tpfs_pkg::*;
;
  localparam int PROG_N = 8; // short programming time keeps the run brief
  logic clk, rstn, regWr, regRd, tblReq, tblReady, flashRdEn, flashGo, opAbort, cpuStall;
  logic [REG_AW-1:0] regAddr; // register offset
  logic [7:0] regWdata, regRdata, d; // bus data and read scratch
  tpfs_tbl_req_t tblCmd; // table instruction
  logic [LOW_W-1:0] flashRdAddr;
  logic [15:0] flashRdData;
  tpfs_flash_cmd_t flashCmd;
  logic [HOLD_BYTES-1:0][7:0] holdData;
  logic [21:0] ptr, acc; // expected pointer and last access address
  int errorCnt, cmpCount, cycCnt, n, i;

  tpfs_top #(.PROG_CYCLES_P(PROG_N)) tpfs_top_inst (.clk(clk), .rstn(rstn),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .tblReq(tblReq), .tblCmd(tblCmd), .tblReady(tblReady),
    .flashRdEn(flashRdEn), .flashRdAddr(flashRdAddr), .flashRdData(flashRdData),
    .flashGo(flashGo), .flashCmd(flashCmd), .holdData(holdData), .opAbort(opAbort),
    .cpuStall(cpuStall));
  tpfs_flash_model tpfs_flash_model_inst (.clk(clk), .rstn(rstn), .flashRdEn(flashRdEn),
    .flashRdAddr(flashRdAddr), .flashRdData(flashRdData));

  // 20 MHz core clock
  always #25 clk = ~clk;

  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycCnt++;
    if (cycCnt == 3000) begin
      errorCnt++;
      stopTest();
    end
  end

  task automatic stopTest();
    if (errorCnt == 0 && cmpCount > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chkVal(input logic [23:0] got, input logic [23:0] exp);
    chkByte(got[23:16], exp[23:16]);
    chkByte(got[15:8], exp[15:8]);
    chkByte(got[7:0], exp[7:0]);
  endtask

  // one-cycle write strobe; returns just after the edge that takes it
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // one-cycle read strobe; data is looked at in the following cycle only
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask

  function automatic logic [7:0] expByte(input logic [21:0] a);
    logic [20:0] w;
    w = a[21:1];
    return a[0] ? (w[7:0] ^ 8'h96) : (w[15:8] ^ w[7:0]);
  endfunction

  task automatic setPtr(input logic [21:0] v);
    wr(OFF_PTR_LOW, v[7:0]);
    wr(OFF_PTR_HIGH, v[15:8]);
    wr(OFF_PTR_UPPER, {2'b00, v[21:16]});
    ptr = v;
  endtask

  task automatic chkPtr();
    logic [7:0] lo, hi, up;
    rd(OFF_PTR_LOW, lo);
    rd(OFF_PTR_HIGH, hi);
    rd(OFF_PTR_UPPER, up);
    chkVal({2'b00, up[5:0], hi, lo}, {2'b00, ptr});
    chkByte({6'h00, up[7:6]}, 8'h00);
  endtask

  // issue one table instruction and track the expected pointer
  task automatic tbl(input logic isWr, input tpfs_mode_t m);
    logic [20:0] low;
    low = ptr[20:0];
    acc = (m == TPFS_PRE_INC) ? {ptr[21], low + 21'h1} : ptr;
    @(posedge clk);
    tblReq <= 1'b1;
    tblCmd <= '{isWrite: isWr, mode: m};
    @(posedge clk);
    tblReq <= 1'b0;
    // only the low 21 bits move, wrapping around
    case (m)
      TPFS_POST_INC: ptr = {ptr[21], low + 21'h1};
      TPFS_POST_DEC: ptr = {ptr[21], low - 21'h1};
      default: ptr = acc;
    endcase
    if (!isWr) begin
      #1 chkVal({3'b000, flashRdEn, 20'h00000}, 24'h100000);
      chkVal({3'b000, flashRdAddr}, {3'b000, acc[21:1]});
    end
  endtask

  // load control, unlock with the key pair, then request the start
  task automatic launch(input logic [7:0] c);
    wr(OFF_CTRL, c & 8'hFD);
    wr(OFF_UNLOCK, UNLOCK_KEY1);
    wr(OFF_UNLOCK, UNLOCK_KEY2);
    wr(OFF_CTRL, c);
    #1 chkVal({7'h00, flashGo, 7'h00, cpuStall, 7'h00, tblReady}, 24'h010100);
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = '0;
    regWdata = 8'h00;
    tblReq = 1'b0;
    tblCmd = '0;
    opAbort = 1'b0;
    errorCnt = 0;
    cmpCount = 0;
    cycCnt = 0;
    ptr = PTR_RESET;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // reset contents, unmapped offset 7 included; control is left out
    for (i = 0; i < 8; i++) begin
      if (i != 4) begin
        rd(3'(i), d);
        chkByte(d, 8'h00);
      end
    end
    chkByte(8'(holdData == {HOLD_BYTES{8'hFF}}), 8'h01);
    // pointer bytes and the dead upper bits
    setPtr(22'h3FFFFF);
    wr(OFF_PTR_UPPER, 8'hFF);
    chkPtr();
    // every update mode, across the 21-bit wrap with the top bit set
    tbl(1'b0, TPFS_POST_INC);
    rd(OFF_LATCH, d);
    chkByte(d, expByte(acc));
    chkPtr();
    tbl(1'b0, TPFS_POST_DEC);
    rd(OFF_LATCH, d);
    chkByte(d, expByte(acc));
    chkPtr();
    tbl(1'b0, TPFS_PRE_INC);
    rd(OFF_LATCH, d);
    chkByte(d, expByte(acc));
    chkPtr();
    tbl(1'b0, TPFS_KEEP);
    rd(OFF_LATCH, d);
    chkByte(d, expByte(acc));
    chkPtr();
    // stores pick a holding byte from the low five bits only
    setPtr(22'h3FFFE5);
    wr(OFF_LATCH, 8'hC3);
    tbl(1'b1, TPFS_KEEP);
    wr(OFF_LATCH, 8'h3C);
    tbl(1'b1, TPFS_POST_INC);
    tbl(1'b1, TPFS_PRE_INC);
    rd(OFF_LATCH, d);
    chkByte(d, 8'h3C);
    chkByte(holdData[5], 8'h3C);
    chkByte(holdData[7], 8'h3C);
    chkByte(holdData[6], 8'hFF);
    chkPtr();
    // bad starts: no pair, permit clear, pair broken by another write
    for (i = 0; i < 3; i++) begin
      wr(OFF_CTRL, 8'h94);
      if (i != 0) wr(OFF_UNLOCK, UNLOCK_KEY1);
      if (i == 2) wr(OFF_PTR_LOW, ptr[7:0]);
      if (i != 0) wr(OFF_UNLOCK, UNLOCK_KEY2);
      wr(OFF_CTRL, (i == 1) ? 8'h92 : 8'h96);
      #1 chkVal({7'h00, flashGo, 7'h00, cpuStall, 7'h00, tblReady}, 24'h000001);
      rd(OFF_CTRL, d);
      chkByte(d & 8'h0A, 8'h08);
    end
    // block write of the holding registers
    launch(8'h86);
    chkVal({7'h00, flashCmd.erase, 16'h0000}, 24'h000000);
    chkVal({7'h00, flashCmd.writeBlk}, {7'h00, ptr[21:5]});
    n = 0;
    while (cpuStall === 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    chkVal(24'(n), 24'(PROG_N));
    chkByte(8'(holdData == {HOLD_BYTES{8'hFF}}), 8'h01);
    rd(OFF_STATUS, d);
    chkByte(d & 8'h01, 8'h01);
    wr(OFF_STATUS, 8'h01);
    rd(OFF_STATUS, d);
    chkByte(d & 8'h01, 8'h00);
    // block erase, with a control write attempted while busy
    setPtr(22'h0ABCDF);
    launch(8'h96);
    chkVal({7'h00, flashCmd.erase, 7'h00, flashCmd.cfgSpace, 8'h00}, 24'h010000);
    chkVal({8'h00, flashCmd.eraseBlk}, {8'h00, ptr[21:6]});
    wr(OFF_CTRL, 8'h00);
    rd(OFF_CTRL, d);
    chkByte(d & 8'h12, 8'h12);
    repeat (PROG_N) @(posedge clk);
    rd(OFF_CTRL, d);
    chkByte(d & 8'h1A, 8'h00);
    rd(OFF_STATUS, d);
    chkByte(d & 8'h01, 8'h01);
    // erase cut short by an abort
    wr(OFF_STATUS, 8'h01);
    launch(8'h96);
    @(posedge clk);
    opAbort <= 1'b1;
    @(posedge clk);
    opAbort <= 1'b0;
    @(posedge clk);
    #1 chkVal({7'h00, cpuStall, 16'h0000}, 24'h000000);
    rd(OFF_CTRL, d);
    chkByte(d & 8'h0A, 8'h08);
    rd(OFF_STATUS, d);
    chkByte(d & 8'h01, 8'h00);
    stopTest();
  end
endmodule
`default_nettype wire
